// ### mstx_pkg.sv
// Package of constants, operation codes and carriers for the skip, table and exclusive-OR unit.
// What this block does
// - Nibble exchange puts operand high nibble low and low nibble high in accumulator.
// - Skip-if-null skips next instruction in two cycles when byte is zero, else one.
// - Copy-skip-if-null loads byte into accumulator and skips when that byte is zero.
// - Bit test skips next instruction in two cycles when selected bit is clear.
// - A taken skip discards the prefetched instruction and inserts one dummy cycle.
// - Current-page table read: ROM low byte to memory, high byte to table-high latch.
// - Final-page table read works alike but addresses the last program page.
// - Exclusive-OR into accumulator changes the accumulator and the zero flag.
// - Exclusive-OR to memory stores the result back and updates the zero flag.
// - Immediate exclusive-OR places result in accumulator and updates the zero flag.
package mstx_pkg;

    // ------------------------------------------------------------------
    // Widths and constants.
    // ------------------------------------------------------------------
    // Default widths; the last program page is the top one of the ROM.
    localparam int DATA_W = 8;
    localparam int ROM_W = 16;
    localparam int ROM_ADDR_W = 15;
    localparam int PTR_W = 8;
    localparam int RAM_ADDR_W = 8;
    localparam int NIB_W = 4;
    localparam int BIT_SEL_W = 3;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [ROM_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [ROM_ADDR_W-1:0] ZERO_ROM_ADDR = 15'h0000;
    localparam logic [RAM_ADDR_W-1:0] ZERO_RAM_ADDR = 8'h00;
    localparam logic [ROM_ADDR_W-PTR_W-1:0] LAST_PAGE = 7'h7f;

    // ------------------------------------------------------------------
    // Operation codes and phases.
    // ------------------------------------------------------------------
    // Operation selected by the decoder.
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_NIBBLE_EXCHANGE = 4'b0001,
        OP_SKIP_IF_NULL = 4'b0010,
        OP_COPY_SKIP_IF_NULL = 4'b0011,
        OP_SKIP_IF_BIT_CLEAR = 4'b0100,
        OP_TABLE_READ_CURRENT_PAGE = 4'b0101,
        OP_TABLE_READ_FINAL_PAGE = 4'b0110,
        OP_XOR_ACC_MEM = 4'b0111,
        OP_EXCLUSIVE_OR_TO_MEMORY = 4'b1000,
        OP_XOR_IMMEDIATE = 4'b1001
    } mstx_op_e;

    // Execution phase.
    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_DUMMY = 2'b01,
        ST_TABLE = 2'b10
    } mstx_state_e;

    // ------------------------------------------------------------------
    // Carriers.
    // ------------------------------------------------------------------
    // Decoded instruction handed in from the fetch/decode stage.
    typedef struct packed {
        mstx_op_e op;
        logic [RAM_ADDR_W-1:0] mem_addr;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [DATA_W-1:0] immediate;
    } mstx_instr_s;

    // Write-back toward accumulator, data memory and zero flag.
    typedef struct packed {
        logic acc_we;
        logic [DATA_W-1:0] acc_data;
        logic mem_we;
        logic [RAM_ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_data;
        logic zero_we;
        logic zero_val;
    } mstx_wb_s;

endpackage

// ### mstx_unit.sv
// Execution unit for nibble exchange, zero-test skips, table reads and exclusive-OR.
`timescale 1ns/1ns
`default_nettype none

module mstx_unit #(
    parameter int DATA_W = mstx_pkg::DATA_W,
    parameter int ROM_W = mstx_pkg::ROM_W,
    parameter int ROM_ADDR_W = mstx_pkg::ROM_ADDR_W,
    parameter int PTR_W = mstx_pkg::PTR_W
) (
    // Clock, reset and enable.
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // Decoded instruction request.
    input wire logic instr_valid,
    input wire mstx_pkg::mstx_instr_s instr,
    output logic instr_ready,
    // Core state sampled with the request.
    input wire logic [DATA_W-1:0] acc_value,
    input wire logic [DATA_W-1:0] mem_rdata,
    input wire logic [ROM_ADDR_W-1:0] pc_value,
    input wire logic [PTR_W-1:0] table_pointer,
    // Program ROM read port.
    output logic rom_req,
    output logic [ROM_ADDR_W-1:0] rom_addr,
    input wire logic [ROM_W-1:0] rom_rdata,
    // Results.
    output mstx_pkg::mstx_wb_s wb,
    output logic [DATA_W-1:0] table_high_latch,
    output logic discard_prefetch,
    output logic done
);

    // ------------------------------------------------------------------
    // Internal state and decoded terms.
    // ------------------------------------------------------------------
    // Timing at a glance: a request is taken on the edge where clk_en,
    // instr_valid and instr_ready are all high. Single-cycle operations
    // show their write-back and done one edge later. A taken skip shows
    // discard_prefetch one edge later and done two edges later, with
    // instr_ready low in between. A table read drives the ROM address in
    // the accept cycle, samples the ROM word one cycle later and shows
    // the memory write, the high byte and done two edges after accept.
    mstx_pkg::mstx_state_e state_reg, state_next;
    mstx_pkg::mstx_wb_s wb_next;
    logic [mstx_pkg::RAM_ADDR_W-1:0] tab_dest_reg;
    logic [DATA_W-1:0] swapped;
    logic [DATA_W-1:0] xor_mem;
    logic [DATA_W-1:0] xor_imm;
    logic skip_taken;
    logic exec;

    // ------------------------------------------------------------------
    // Request acceptance.
    // ------------------------------------------------------------------
    // The unit accepts a request only in the execute phase.
    // A low clock enable blocks acceptance too, so a stalled request is
    // simply offered again on the next enabled edge.
    assign instr_ready = (state_reg == mstx_pkg::ST_EXEC);
    assign exec = clk_en && instr_valid && instr_ready;

    // ------------------------------------------------------------------
    // Operand datapath.
    // ------------------------------------------------------------------
    // The exchanged byte goes only to the accumulator; the memory copy stays as it was.
    // Nibble exchange of the operand via one generate loop over nibble bits.
    genvar gi;
    generate
        for (gi = 0; gi < mstx_pkg::NIB_W; gi++) begin : g_swap
            assign swapped[gi] = mem_rdata[gi + mstx_pkg::NIB_W];
            assign swapped[gi + mstx_pkg::NIB_W] = mem_rdata[gi];
        end
    endgenerate

    // Exclusive-OR results for the memory and immediate forms.
    assign xor_mem = acc_value ^ mem_rdata;
    assign xor_imm = acc_value ^ instr.immediate;

    // ------------------------------------------------------------------
    // Skip decision.
    // ------------------------------------------------------------------
    // Skip decision for the three zero-test operations.
    // Every other operation yields no skip, so no stray dummy cycle follows it.
    always_comb begin
        case (instr.op)
            mstx_pkg::OP_SKIP_IF_NULL: skip_taken = (mem_rdata == mstx_pkg::ZERO_BYTE);
            mstx_pkg::OP_COPY_SKIP_IF_NULL: skip_taken = (mem_rdata == mstx_pkg::ZERO_BYTE);
            mstx_pkg::OP_SKIP_IF_BIT_CLEAR: skip_taken = !mem_rdata[instr.bit_sel];
            default: skip_taken = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Program ROM access.
    // ------------------------------------------------------------------
    // ROM address: current page keeps the program counter's page, final page the last one.
    // The address is combinational so that the ROM word can arrive one cycle later.
    always_comb begin
        rom_req = 1'b0;
        rom_addr = mstx_pkg::ZERO_ROM_ADDR;
        if (exec && instr.op == mstx_pkg::OP_TABLE_READ_CURRENT_PAGE) begin
            rom_req = 1'b1;
            rom_addr = {pc_value[ROM_ADDR_W-1:PTR_W], table_pointer};
        end else if (exec && instr.op == mstx_pkg::OP_TABLE_READ_FINAL_PAGE) begin
            rom_req = 1'b1;
            rom_addr = {mstx_pkg::LAST_PAGE, table_pointer};
        end
    end

    // ------------------------------------------------------------------
    // Phase control.
    // ------------------------------------------------------------------
    // Next-phase selection; taken skips and table reads both cost a second cycle.
    // Dummy and table cycles always fall back to execute, so no state can lock the unit.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mstx_pkg::ST_EXEC: begin
                if (exec && skip_taken) begin
                    state_next = mstx_pkg::ST_DUMMY;
                end else if (rom_req) begin
                    state_next = mstx_pkg::ST_TABLE;
                end
            end
            mstx_pkg::ST_DUMMY: state_next = mstx_pkg::ST_EXEC;
            mstx_pkg::ST_TABLE: state_next = mstx_pkg::ST_EXEC;
            default: state_next = mstx_pkg::ST_EXEC;
        endcase
    end

    // ------------------------------------------------------------------
    // Write-back selection.
    // ------------------------------------------------------------------
    // Write-back selection; only exclusive-OR operations touch the zero flag.
    // Skips and table reads never raise zero_we, which leaves every status flag alone.
    always_comb begin
        wb_next = '0;
        wb_next.mem_addr = instr.mem_addr;
        if (state_reg == mstx_pkg::ST_TABLE) begin
            wb_next.mem_we = 1'b1;
            wb_next.mem_addr = tab_dest_reg;
            wb_next.mem_data = rom_rdata[DATA_W-1:0];
        end else if (exec) begin
            case (instr.op)
                mstx_pkg::OP_NIBBLE_EXCHANGE: begin
                    wb_next.acc_we = 1'b1;
                    wb_next.acc_data = swapped;
                end
                mstx_pkg::OP_COPY_SKIP_IF_NULL: begin
                    wb_next.acc_we = 1'b1;
                    wb_next.acc_data = mem_rdata;
                end
                mstx_pkg::OP_XOR_ACC_MEM: begin
                    wb_next.acc_we = 1'b1;
                    wb_next.acc_data = xor_mem;
                    wb_next.zero_we = 1'b1;
                    wb_next.zero_val = (xor_mem == mstx_pkg::ZERO_BYTE);
                end
                mstx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: begin
                    wb_next.mem_we = 1'b1;
                    wb_next.mem_data = xor_mem;
                    wb_next.zero_we = 1'b1;
                    wb_next.zero_val = (xor_mem == mstx_pkg::ZERO_BYTE);
                end
                mstx_pkg::OP_XOR_IMMEDIATE: begin
                    wb_next.acc_we = 1'b1;
                    wb_next.acc_data = xor_imm;
                    wb_next.zero_we = 1'b1;
                    wb_next.zero_val = (xor_imm == mstx_pkg::ZERO_BYTE);
                end
                default: wb_next.acc_we = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    // Every register holds while clk_en is low, so a result stands until the next
    // enabled edge.
    // Phase register.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_reg <= mstx_pkg::ST_EXEC;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // Table destination address held across the ROM access.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tab_dest_reg <= mstx_pkg::ZERO_RAM_ADDR;
        end else if (clk_en && rom_req) begin
            tab_dest_reg <= instr.mem_addr;
        end
    end

    // Table-high latch takes the ROM word's high byte.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            table_high_latch <= mstx_pkg::ZERO_BYTE;
        end else if (clk_en && state_reg == mstx_pkg::ST_TABLE) begin
            table_high_latch <= rom_rdata[ROM_W-1:DATA_W];
        end
    end

    // Registered write-back, discard and completion outputs.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wb <= '0;
            discard_prefetch <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            wb <= wb_next;
            discard_prefetch <= exec && skip_taken;
            done <= (exec && !skip_taken && !rom_req) || (state_reg != mstx_pkg::ST_EXEC);
        end
    end

endmodule // mstx_unit

`default_nettype wire

// ### mstx_unit_monitor.sv
// Port-level checker for the skip, table and exclusive-OR unit.
`timescale 1ns/1ns
`default_nettype none
module mstx_monitor (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Request side.
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire mstx_pkg::mstx_instr_s instr,
    input wire logic instr_ready,
    input wire logic [7:0] acc_value,
    input wire logic [7:0] mem_rdata,
    input wire logic [14:0] pc_value,
    input wire logic [7:0] table_pointer,
    // Result side.
    input wire logic rom_req,
    input wire logic [14:0] rom_addr,
    input wire logic [15:0] rom_rdata,
    input wire mstx_pkg::mstx_wb_s wb,
    input wire logic [7:0] table_high_latch,
    input wire logic discard_prefetch,
    input wire logic done
);
    // ------------------------------------------------------------------
    // Clocking.
    // ------------------------------------------------------------------
    // All properties share the unit's clock and are void while reset is held.
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Accepted requests, sorted by the kinds the properties need.
    wire tk = clk_en && instr_valid && instr_ready;
    wire fin = instr.op == mstx_pkg::OP_TABLE_READ_FINAL_PAGE;
    wire t_tab = tk && (fin || instr.op == mstx_pkg::OP_TABLE_READ_CURRENT_PAGE);
    // ------------------------------------------------------------------
    // Properties.
    // ------------------------------------------------------------------
    // Each property except p_dmy starts at an accepted request and checks the answer it earns; p_dmy starts at a discard pulse.
    property p_nib; tk && instr.op == mstx_pkg::OP_NIBBLE_EXCHANGE |=> wb.acc_we && !wb.zero_we
        && wb.acc_data == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}; endproperty
    a_nib: assert property (p_nib) else $error("bad nibble exchange");
    property p_sz; tk && instr.op == mstx_pkg::OP_SKIP_IF_NULL
        |=> discard_prefetch == ($past(mem_rdata) == 8'h00); endproperty
    a_sz: assert property (p_sz) else $error("bad null skip");
    property p_cp; tk && instr.op == mstx_pkg::OP_COPY_SKIP_IF_NULL && mem_rdata != 8'h00
        |=> done && !discard_prefetch; endproperty
    a_cp: assert property (p_cp) else $error("bad copy skip");
    property p_bit; tk && instr.op == mstx_pkg::OP_SKIP_IF_BIT_CLEAR
        |=> discard_prefetch != $past(mem_rdata[instr.bit_sel]); endproperty
    a_bit: assert property (p_bit) else $error("bad bit skip");
    property p_dmy; discard_prefetch |-> !instr_ready && !done ##1 done && instr_ready; endproperty
    a_dmy: assert property (p_dmy) else $error("bad dummy cycle");
    property p_tad; t_tab |-> rom_req
        && rom_addr == {fin ? mstx_pkg::LAST_PAGE : pc_value[14:8], table_pointer}; endproperty
    a_tad: assert property (p_tad) else $error("bad table address");
    property p_tdat; t_tab |=> !instr_ready ##1 done && wb.mem_we && !wb.zero_we
        && {table_high_latch, wb.mem_data} == $past(rom_rdata); endproperty
    a_tdat: assert property (p_tdat) else $error("bad table data");
    property p_xz; tk && instr.op == mstx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY |=> wb.mem_we
        && wb.zero_we && wb.zero_val == ($past(acc_value ^ mem_rdata) == 8'h00); endproperty
    a_xz: assert property (p_xz) else $error("bad memory xor");
endmodule // mstx_monitor
bind mstx_unit mstx_monitor mon_u (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .instr_valid(instr_valid),
    .instr(instr),
    .instr_ready(instr_ready),
    .acc_value(acc_value),
    .mem_rdata(mem_rdata),
    .pc_value(pc_value),
    .table_pointer(table_pointer),
    .rom_req(rom_req),
    .rom_addr(rom_addr),
    .rom_rdata(rom_rdata),
    .wb(wb),
    .table_high_latch(table_high_latch),
    .discard_prefetch(discard_prefetch),
    .done(done)
);
`default_nettype wire

// ### mcu_skip_table_xor_ops_test.sv
// Self-checking bench for the skip, table and exclusive-OR unit.
`timescale 1ns/1ns
`default_nettype none
module mcu_skip_table_xor_ops_test;
    logic clock = 0, reset_n = 0, instr_valid = 0, clk_en = 1;
    logic [7:0] acc_value = 0, mem_rdata = 0, table_pointer = 0, table_high_latch;
    logic [14:0] pc_value = 0, rom_addr;
    logic [15:0] rom_rdata = 0;
    logic instr_ready, rom_req, discard_prefetch, done;
    mstx_pkg::mstx_instr_s instr = '0;
    mstx_pkg::mstx_wb_s wb;
    int errors = 0, n_tests = 0, seed = 32'h4c30, cyc = 0;
    // ------------------------------------------------------------------
    // Unit under test, clock and hang limit.
    // ------------------------------------------------------------------
    // Unit under test; the clock enable is driven so that stalls are exercised.
    mstx_unit dut_u (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .instr_valid(instr_valid),
        .instr(instr),
        .instr_ready(instr_ready),
        .acc_value(acc_value),
        .mem_rdata(mem_rdata),
        .pc_value(pc_value),
        .table_pointer(table_pointer),
        .rom_req(rom_req),
        .rom_addr(rom_addr),
        .rom_rdata(rom_rdata),
        .wb(wb),
        .table_high_latch(table_high_latch),
        .discard_prefetch(discard_prefetch),
        .done(done)
    );
    // Clock and hang limit.
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            close_out();
        end
    end
    // ------------------------------------------------------------------
    // Checking and verdict.
    // ------------------------------------------------------------------
    // Compare one result with its expected value.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Stimulus and model.
    // ------------------------------------------------------------------
    // Issue one instruction with random operands and check every result against the model.
    task automatic issue(input mstx_pkg::mstx_op_e op);
        logic [7:0] a = 8'($random(seed)), k = 8'($random(seed)), p = 8'($random(seed));
        logic [7:0] ad = 8'($random(seed)), m = 8'($random(seed) & $random(seed) & $random(seed));
        logic [15:0] r = 16'($random(seed));
        logic [14:0] pc = 15'($random(seed)), ra;
        logic [2:0] bs = 3'($random(seed));
        logic st = 2'($random(seed)) == 2'h0;
        logic [3:0] n = 0, na = 0, nm = 0, nd = 0;
        logic [7:0] x, ac;
        logic tb, xo, em, ea, sk;
        tb = op inside {mstx_pkg::OP_TABLE_READ_CURRENT_PAGE, mstx_pkg::OP_TABLE_READ_FINAL_PAGE};
        xo = op inside {mstx_pkg::OP_XOR_ACC_MEM, mstx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY,
            mstx_pkg::OP_XOR_IMMEDIATE};
        em = tb || op == mstx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY;
        ea = op inside {mstx_pkg::OP_NIBBLE_EXCHANGE, mstx_pkg::OP_COPY_SKIP_IF_NULL} || xo && !em;
        sk = op inside {mstx_pkg::OP_SKIP_IF_NULL, mstx_pkg::OP_COPY_SKIP_IF_NULL} ? m == 0
            : op == mstx_pkg::OP_SKIP_IF_BIT_CLEAR && !m[bs];
        x = op == mstx_pkg::OP_XOR_IMMEDIATE ? a ^ k : a ^ m;
        ac = op == mstx_pkg::OP_NIBBLE_EXCHANGE ? {m[3:0], m[7:4]}
            : op == mstx_pkg::OP_COPY_SKIP_IF_NULL ? m : x;
        ra = {op == mstx_pkg::OP_TABLE_READ_FINAL_PAGE ? mstx_pkg::LAST_PAGE : pc[14:8], p};
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= {op, ad, bs, k};
        acc_value <= a;
        mem_rdata <= m;
        pc_value <= pc;
        table_pointer <= p;
        #1;
        chk({rom_req, rom_addr}, {tb, tb ? ra : 15'h0000});
        @(posedge clock);
        instr_valid <= 1'b0;
        rom_rdata <= r;
        // Now and then stall the edge after a single-cycle result.
        clk_en <= !(st && !sk && !tb);
        // Watch every cycle until the completion pulse.
        do begin
            #1;
            n++;
            if (wb.acc_we) chk(wb.acc_data, ac);
            if (wb.mem_we) chk({wb.mem_addr, wb.mem_data}, {ad, tb ? r[7:0] : x});
            if (wb.zero_we) chk({xo, wb.zero_val}, {1'b1, x == 0});
            na += wb.acc_we;
            nm += wb.mem_we;
            nd += discard_prefetch;
            if (!done) @(posedge clock);
        end while (!done && n < 4);
        chk(16'(n), (sk || tb) ? 16'h0002 : 16'h0001);
        chk({na, nm, nd}, {4'(ea), 4'(em), 4'(sk)});
        if (tb) chk(table_high_latch, r[15:8]);
        // A low clock enable must hold the finished result on the outputs.
        if (st && !sk && !tb) begin
            @(posedge clock);
            clk_en <= 1'b1;
            #1;
            chk({done, wb.acc_we, wb.mem_we, wb.zero_we}, {1'b1, ea, em, xo});
        end
    endtask
    // Reset for twelve cycles, then run a random mix of every operation code.
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (300) issue(mstx_pkg::mstx_op_e'(4'($unsigned($random(seed)) % 10)));
        close_out();
    end
endmodule // mcu_skip_table_xor_ops_test
`default_nettype wire
